// [logic/mac_rx_classify_regs.svh]
/*
 Register offsets, field positions, reset values and counts for the receive
 classifier, management shifter and MII/RMII mapper. Assumes a plain
 one-cycle register port and a 100 MHz system clock.
*/
// Overview of operation
// - Copy-all mode stores every clean received frame, whatever its address.
// - Copy-all still drops long, short, bad-FCS and receive-error frames.
// - Configuration bit 19 keeps frames whose FCS check failed.
// - Type match value compared to bytes 13-14; equal sets status bit 22.
// - Type match value resets to zero.
// - Type match never changes whether a frame is stored.
// - VLAN tag is 0x8100 then priority, CFI and a 12-bit VID.
// - Configuration bit 8 raises the length limit from 1518 to 1536.
// - Status bit 21 set when the type field is 0x8100.
// - Status bit 20 set for tagged frames with null VID, with bit 21.
// - Tagged frames copy priority into bits 19:17 and CFI into bit 16.
// - Writing the management register starts a shift; status bit 2 ends it.
// - Divider setting bits 11:10 = 2'b10 gives about 2000 clocks.
// - Completion pulse rises together with the status bit.
// - Each MDC cycle after the 32-bit preamble loads the LSB from MDIO and drives the MSB out, except from turnaround on in reads.
// - Reads mid-shift return the partly shifted register.
// - After the shift bits are back in place; reads hold PHY data.
// - RMII select bit picks RMII when set, MII when clear.
// - RMII moves 2-bit data at twice the rate on the reference clock.
// - RMII combines carrier sense with data valid; TX error, collision unused.
`ifndef MAC_RX_CLASSIFY_REGS_SVH
`define MAC_RX_CLASSIFY_REGS_SVH
`define OFF_NCFGR     8'h04
`define OFF_NSR       8'h08
`define OFF_MAN       8'h34
`define OFF_TYPE      8'hb8
`define OFF_USRIO     8'hc0
`define OFF_RXSTAT    8'hd0
`define NCFGR_RST     32'h0000_0800
`define CFG_COPY_ALL  4
`define CFG_BIG       8
`define CFG_DIV_LO    10
`define CFG_DIV_HI    11
`define CFG_IGN_FCS   19
`define NSR_IDLE      2
`define USRIO_RMII    0
`define ST_TYPE_HIT   22
`define ST_VLAN       21
`define ST_PRIO_TAG   20
`define ST_PRIO_HI    19
`define ST_PRIO_LO    17
`define ST_CFI        16
`define TPID_VLAN     16'h8100
`define VID_NULL      12'h000
`define SFD_BYTE      8'hd5
`define CRC_INIT      32'hffff_ffff
`define CRC_POLY      32'hedb8_8320
`define CRC_RESIDUE   32'hdebb_20e3
`define LEN_MIN       14'h0040
`define LEN_MAX       14'h05ee
`define LEN_MAX_BIG   14'h0600
`define LEN_SAT       14'h3fff
`define BYTE_TYPE_HI  14'h000c
`define BYTE_TYPE_LO  14'h000d
`define BYTE_TCI_HI   14'h000e
`define BYTE_TCI_LO   14'h000f
`define MDC_HALF_BASE 6'h04
`define MGMT_PRE      7'h20
`define MGMT_TA       7'h2e
`define MGMT_LAST     7'h3f
`define MGMT_NOM_CYC  12'h800
`define READ_OP_BIT   29
`endif

// [logic/mac_rx_pkg.sv]
/*
 Types shared by the receive classifier.
 Assumes the constants header is included beside it.
*/
package mac_rx_pkg;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_HUNT = 2'b01,
      RX_DATA = 2'b10
   } rx_state_t;
endpackage

// [logic/mac_rx_classify_mdio_phy_if.sv]
/*
 Receive classification, management shift register with MDC divider and
 MII/RMII pin mapping for a 10/100 MAC. Assumes link pins arrive
 asynchronously and the MAC core and address filter share clk_sys_i.
*/
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mac_rx_classify_regs.svh"
module mac_rx_classify_mdio_phy_if (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   // Register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // Management link
   output logic             mdc_o,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe_n_o,
   output logic             mgmt_done_o,
   // Receive pins
   input  wire logic        rx_clock_pin_i,
   input  wire logic        tx_clock_or_ref_clock_pin_i,
   input  wire logic [3:0]  rx_data_pins_i,
   input  wire logic        rx_data_valid_pin_i,
   input  wire logic        rx_error_pin_i,
   input  wire logic        carrier_sense_pin_i,
   input  wire logic        collision_detect_pin_i,
   // Transmit pins
   output logic             tx_enable_pin_o,
   output logic      [3:0]  tx_data_pins_o,
   output logic             tx_error_pin_o,
   // MAC core side
   input  wire logic [3:0]  tx_nibble_i,
   input  wire logic        tx_en_i,
   input  wire logic        tx_err_i,
   output logic             tx_nibble_take_o,
   input  wire logic        addr_match_i,
   output logic             crs_o,
   output logic             col_o,
   output logic             rx_done_o,
   output logic             rx_accept_o,
   output logic      [31:0] rx_status_o
);
   import mac_rx_pkg::*;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Registers
   logic [31:0] ncfgr;
   logic [31:0] man_sr;
   logic [15:0] type_match;
   logic        rmii_sel;
   logic        mgmt_idle;

   // Two-stage pin synchronisers, third stage for edges
   logic [12:0] pin_s1;
   logic [12:0] pin_s2;
   logic        rxck_s3;
   logic        txck_s3;
   logic        rxck_s;
   logic        txck_s;
   logic [3:0]  rxd_s;
   logic        rxdv_s;
   logic        rxer_s;
   logic        mdio_s;
   logic        rx_edge;
   logic        tx_edge;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_s1  <= '0;
         pin_s2  <= '0;
         rxck_s3 <= 1'b0;
         txck_s3 <= 1'b0;
      end else begin
         pin_s1  <= {mdio_i, carrier_sense_pin_i, collision_detect_pin_i, rx_error_pin_i,
                     rx_data_valid_pin_i, rx_data_pins_i, tx_clock_or_ref_clock_pin_i,
                     rx_clock_pin_i, 2'b00};
         pin_s2  <= pin_s1;
         rxck_s3 <= rxck_s;
         txck_s3 <= txck_s;
      end
   end

   assign rxck_s = rmii_sel ? pin_s2[3] : pin_s2[2];
   assign txck_s = pin_s2[3];
   assign rxd_s  = pin_s2[7:4];
   assign rxdv_s = pin_s2[8];
   assign rxer_s = pin_s2[9];
   assign mdio_s = pin_s2[12];
   // RMII receive is timed by the reference clock
   assign rx_edge = rxck_s & ~rxck_s3;
   assign tx_edge = txck_s & ~txck_s3;

   // Register writes
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ncfgr      <= `NCFGR_RST;
         type_match <= 16'h0000;
         rmii_sel   <= 1'b0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `OFF_NCFGR: ncfgr      <= reg_wdata_i;
            `OFF_TYPE:  type_match <= reg_wdata_i[15:0];
            `OFF_USRIO: rmii_sel   <= reg_wdata_i[`USRIO_RMII];
            default:    ncfgr      <= ncfgr;
         endcase
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `OFF_NCFGR:  reg_rdata_o <= ncfgr;
            `OFF_NSR:    reg_rdata_o <= 32'(mgmt_idle) << `NSR_IDLE;
            `OFF_MAN:    reg_rdata_o <= man_sr;
            `OFF_TYPE:   reg_rdata_o <= {16'h0000, type_match};
            `OFF_USRIO:  reg_rdata_o <= {31'h0, rmii_sel};
            `OFF_RXSTAT: reg_rdata_o <= rx_status_o;
            default:     reg_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   // Management shifter
   logic       mgmt_busy;
   logic       read_op;
   logic [5:0] div_cnt;
   logic [6:0] bit_cnt;
   logic [5:0] half;
   logic       mdc_rise;
   logic       mdc_fall;
   logic       man_wr;

   // divider chosen by bits 11:10, 8/16/32/64 clocks per MDC
   assign half     = 6'(`MDC_HALF_BASE << ncfgr[`CFG_DIV_HI:`CFG_DIV_LO]);
   assign mdc_rise = mgmt_busy && (div_cnt == half - 6'h01);
   assign mdc_fall = mgmt_busy && (div_cnt == {half[4:0], 1'b0} - 6'h01);
   assign man_wr   = reg_wr_i && (reg_addr_i == `OFF_MAN);

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         man_sr      <= 32'h0000_0000;
         mgmt_busy   <= 1'b0;
         mgmt_idle   <= 1'b1;
         mgmt_done_o <= 1'b0;
         read_op     <= 1'b0;
         div_cnt     <= 6'h00;
         bit_cnt     <= 7'h00;
         mdc_o       <= 1'b0;
         mdio_o      <= 1'b1;
         mdio_oe_n_o <= 1'b1;
      end else if (man_wr) begin
         // a write starts the shift; frame image is taken as given
         man_sr      <= reg_wdata_i;
         read_op     <= reg_wdata_i[`READ_OP_BIT];
         mgmt_busy   <= 1'b1;
         mgmt_idle   <= 1'b0;
         mgmt_done_o <= 1'b0;
         div_cnt     <= 6'h00;
         bit_cnt     <= 7'h00;
         mdc_o       <= 1'b0;
         mdio_o      <= 1'b1;
         mdio_oe_n_o <= 1'b0;
      end else begin
         mgmt_done_o <= 1'b0;
         if (mgmt_busy) begin
            div_cnt <= div_cnt + 6'h01;
         end
         if (mdc_rise) begin
            mdc_o <= 1'b1;
            // LSB loads from MDIO; the 32 shifts rotate back
            if (bit_cnt >= `MGMT_PRE) begin
               man_sr <= {man_sr[30:0], mdio_s};
            end
         end
         if (mdc_fall) begin
            div_cnt <= 6'h00;
            mdc_o   <= 1'b0;
            bit_cnt <= bit_cnt + 7'h01;
            if (bit_cnt == `MGMT_LAST) begin
               // completion pulse with the status bit
               mgmt_busy   <= 1'b0;
               mgmt_idle   <= 1'b1;
               mgmt_done_o <= 1'b1;
               mdio_o      <= 1'b1;
               mdio_oe_n_o <= 1'b1;
            end else begin
               // MSB driven out; preamble ones before it
               mdio_o      <= (bit_cnt + 7'h01 >= `MGMT_PRE) ? man_sr[31] : 1'b1;
               // Release the line from turnaround on for reads
               mdio_oe_n_o <= read_op && (bit_cnt + 7'h01 >= `MGMT_TA);
            end
         end
      end
   end

   // Receive byte assembly and classification
   rx_state_t   rx_state;
   logic [7:0]  byte_sr;
   logic [7:0]  next_byte;
   logic [1:0]  unit_cnt;
   logic        last_unit;
   logic [13:0] byte_cnt;
   logic [31:0] crc;
   logic        rxer_seen;
   logic [15:0] rx_type;
   logic [15:0] rx_tci;
   logic        len_bad;
   logic        frame_clean;
   logic        vlan;
   logic        frame_end;

   always_comb begin
      // dibits in RMII, nibbles in MII, LSB first
      next_byte = rmii_sel ? {rxd_s[1:0], byte_sr[7:2]} : {rxd_s, byte_sr[7:4]};
      last_unit = rmii_sel ? (unit_cnt == 2'b11) : (unit_cnt == 2'b01);
   end

   // long frames allowed by bit 8
   assign len_bad     = (byte_cnt < `LEN_MIN) ||
                        (byte_cnt > (ncfgr[`CFG_BIG] ? `LEN_MAX_BIG : `LEN_MAX));
   // length, FCS and receive error all disqualify; bit 19 lets FCS pass
   assign frame_clean = !rxer_seen && !len_bad &&
                        ((crc == `CRC_RESIDUE) || ncfgr[`CFG_IGN_FCS]);
   assign vlan        = (rx_type == `TPID_VLAN);
   assign frame_end   = rx_edge && !rxdv_s && (rx_state == RX_DATA);

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_state  <= RX_IDLE;
         byte_sr   <= 8'h00;
         unit_cnt  <= 2'b00;
         byte_cnt  <= 14'h0000;
         crc       <= `CRC_INIT;
         rxer_seen <= 1'b0;
         rx_type   <= 16'h0000;
         rx_tci    <= 16'h0000;
      end else if (rx_edge) begin
         if (rxdv_s && rxer_s) begin
            rxer_seen <= 1'b1;
         end
         case (rx_state)
            RX_IDLE: begin
               rxer_seen <= rxdv_s && rxer_s;
               if (rxdv_s) begin
                  rx_state <= RX_HUNT;
                  byte_sr  <= next_byte;
               end
            end
            RX_HUNT: begin
               byte_sr <= next_byte;
               if (!rxdv_s) begin
                  rx_state <= RX_IDLE;
               end else if (next_byte == `SFD_BYTE) begin
                  rx_state <= RX_DATA;
                  unit_cnt <= 2'b00;
                  byte_cnt <= 14'h0000;
                  crc      <= `CRC_INIT;
               end
            end
            RX_DATA: begin
               if (!rxdv_s) begin
                  rx_state <= RX_IDLE;
               end else begin
                  byte_sr  <= next_byte;
                  unit_cnt <= last_unit ? 2'b00 : unit_cnt + 2'b01;
                  if (last_unit) begin
                     crc <= crc_byte(crc, next_byte);
                     if (byte_cnt != `LEN_SAT) begin
                        byte_cnt <= byte_cnt + 14'h0001;
                     end
                     // bytes 13 and 14 form the length/type field
                     if (byte_cnt == `BYTE_TYPE_HI) rx_type[15:8] <= next_byte;
                     if (byte_cnt == `BYTE_TYPE_LO) rx_type[7:0]  <= next_byte;
                     if (byte_cnt == `BYTE_TCI_HI)  rx_tci[15:8]  <= next_byte;
                     if (byte_cnt == `BYTE_TCI_LO)  rx_tci[7:0]   <= next_byte;
                  end
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // Frame verdict and descriptor status
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_done_o   <= 1'b0;
         rx_accept_o <= 1'b0;
         rx_status_o <= 32'h0000_0000;
      end else begin
         rx_done_o <= frame_end;
         if (frame_end) begin
            // copy-all stores any clean frame; type match not used here
            rx_accept_o <= frame_clean && (ncfgr[`CFG_COPY_ALL] || addr_match_i);
            rx_status_o <= 32'h0000_0000;
            rx_status_o[`ST_TYPE_HIT] <= (rx_type == type_match);
            rx_status_o[`ST_VLAN]     <= vlan;
            // null VID marks a priority tag
            rx_status_o[`ST_PRIO_TAG] <= vlan && (rx_tci[11:0] == `VID_NULL);
            // priority and CFI copied for tagged frames
            rx_status_o[`ST_PRIO_HI:`ST_PRIO_LO] <= vlan ? rx_tci[15:13] : 3'b000;
            rx_status_o[`ST_CFI]      <= vlan && rx_tci[12];
         end else begin
            rx_accept_o <= 1'b0;
         end
      end
   end

   // Pin mapping
   logic tx_phase;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         crs_o            <= 1'b0;
         col_o            <= 1'b0;
         tx_enable_pin_o  <= 1'b0;
         tx_data_pins_o   <= 4'h0;
         tx_error_pin_o   <= 1'b0;
         tx_nibble_take_o <= 1'b0;
         tx_phase         <= 1'b0;
      end else begin
         // RMII when the select bit is set
         // combined carrier/valid in RMII, collision unused
         crs_o <= rmii_sel ? rxdv_s : pin_s2[11];
         col_o <= rmii_sel ? 1'b0 : pin_s2[10];
         tx_nibble_take_o <= 1'b0;
         if (tx_edge) begin
            tx_enable_pin_o <= tx_en_i;
            if (rmii_sel) begin
               // two dibits per nibble, low pair first
               tx_data_pins_o   <= {2'b00, tx_phase ? tx_nibble_i[3:2] : tx_nibble_i[1:0]};
               tx_error_pin_o   <= 1'b0;
               tx_nibble_take_o <= tx_phase;
               tx_phase         <= ~tx_phase;
            end else begin
               tx_data_pins_o   <= tx_nibble_i;
               tx_error_pin_o   <= tx_err_i;
               tx_nibble_take_o <= 1'b1;
               tx_phase         <= 1'b0;
            end
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   logic [11:0] busy_cycles;
   logic [31:0] man_start;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_cycles <= 12'h000;
         man_start   <= 32'h0000_0000;
      end else if (man_wr) begin
         busy_cycles <= 12'h000;
         man_start   <= reg_wdata_i;
      end else if (mgmt_busy) begin
         busy_cycles <= busy_cycles + 12'h001;
      end
   end

   sequence shift_rise_s;
      mdc_rise && (bit_cnt >= `MGMT_PRE);
   endsequence

   a_mgmt_done_pulse: assert property ($rose(mgmt_idle) |-> mgmt_done_o ##1 !mgmt_done_o)
      else $error("completion pulse not aligned with status bit");
   a_mgmt_op_length: assert property (($fell(mgmt_busy) &&
      (ncfgr[`CFG_DIV_HI:`CFG_DIV_LO] == 2'b10))
      |-> (busy_cycles == `MGMT_NOM_CYC))
      else $error("management operation length wrong");
   a_mdio_lsb_load: assert property (shift_rise_s |=> man_sr[0] == $past(mdio_s))
      else $error("LSB not loaded from MDIO");
   a_mdc_toggles: assert property (mdc_rise |=> mdc_o ##1 !mgmt_idle)
      else $error("MDC did not rise");
   a_rotate_back: assert property (($fell(mgmt_busy) && !read_op && !man_wr)
      |-> (man_sr == man_start))
      else $error("shift register not restored");
   a_copy_all_keep: assert property ((frame_end && ncfgr[`CFG_COPY_ALL] && frame_clean)
      |=> rx_done_o && rx_accept_o)
      else $error("clean frame dropped in copy-all mode");
   a_error_drop: assert property ((frame_end && (rxer_seen || len_bad)) |=> !rx_accept_o)
      else $error("bad frame accepted");
   a_prio_vlan: assert property (rx_status_o[`ST_PRIO_TAG] |-> rx_status_o[`ST_VLAN])
      else $error("priority tag without VLAN flag");
   a_vlan_flag: assert property (frame_end |=> rx_status_o[`ST_VLAN] == $past(vlan))
      else $error("VLAN flag mismatch");
   a_rmii_no_txer: assert property (rmii_sel && tx_edge |=> !tx_error_pin_o)
      else $error("transmit error driven in RMII");
endmodule

// [testbench/phy_link_model.sv]
/*
 PHY stand-in: sends MII/RMII receive frames and answers MDIO reads.
 Assumes the MAC samples every link pin with its own system clock.
*/
`timescale 1ns/1ps
module phy_link_model (
   // Management side
   input  wire logic       mdc_i,
   input  wire logic       mdio_drv_i,
   input  wire logic       mdio_oe_n_i,
   output logic            mdio_line_o,
   // Receive side
   output logic            lclk_o,
   output logic      [3:0] rxd_o,
   output logic            dv_o,
   output logic            rxer_o,
   output logic            col_o
);
   int          cnt = 0;
   logic [31:0] seen;
   logic [15:0] dat = 16'hc3a5;
   logic        rd_op = 0;
   logic        phy_en = 0;
   logic        phy_bit = 0;
   logic [7:0]  fr [0:1599];
   // Pull-up holds the line high when nobody drives
   assign mdio_line_o = !mdio_oe_n_i ? mdio_drv_i : (phy_en ? phy_bit : 1'b1);
   initial begin
      {lclk_o, rxd_o, dv_o, rxer_o, col_o} = '0;
   end
   // Frame bits captured MSB first after the preamble
   always @(posedge mdc_i) begin
      if (cnt >= 32) seen <= {seen[30:0], mdio_line_o};
      if (cnt == 35) rd_op <= ({seen[0], mdio_line_o} == 2'b10);
      cnt <= (cnt == 63) ? 0 : cnt + 1;
   end
   // clause 22 read: second turnaround bit low, then data
   always @(negedge mdc_i) begin
      phy_en  <= rd_op && cnt >= 47;
      phy_bit <= (cnt >= 48) ? dat[63 - cnt] : 1'b0;
   end
   task tick(input logic [3:0] d);
      rxd_o = d;
      #40 lclk_o = 1;
      #40 lclk_o = 0;
   endtask
   // Link clock runs only inside frames and for three ticks after; collision raised to test RMII
   task send(input int n, input logic [15:0] ty, input logic [15:0] tci,
             input bit bad, input bit err, input bit rmii);
      logic [31:0] c;
      logic [7:0]  b;
      int          i, j;
      c = '1;
      for (i = 0; i < n - 4; i++) begin
         b = i < 6 ? 8'hff : i == 12 ? ty[15:8] : i == 13 ? ty[7:0] :
             i == 14 ? tci[15:8] : i == 15 ? tci[7:0] : i[7:0];
         fr[i] = b;
         c ^= {24'h0, b};
         for (j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
      end
      c = ~c ^ {31'h0, bad};
      for (i = 0; i < 4; i++) fr[n - 4 + i] = c[8 * i +: 8];
      dv_o = 1;
      col_o = rmii;
      for (i = -8; i < n; i++) begin
         b = i < 0 ? (i == -1 ? 8'hd5 : 8'h55) : fr[i];
         rxer_o = err && i == 20;
         // dibits LSB first in RMII, low nibble first in MII
         if (rmii) for (j = 0; j < 4; j++) tick({2'b00, b[2 * j +: 2]});
         else begin
            tick(b[3:0]);
            tick(b[7:4]);
         end
      end
      {dv_o, col_o, rxer_o} = '0;
      repeat (3) tick(~rxd_o);
   endtask
endmodule

// [testbench/mac_rx_classify_mdio_phy_if_bench.sv]
/*
 Self-checking bench for receive classing, management shift and pin mapping.
 Assumes the PHY stand-in and the shared constants header.
*/
`timescale 1ns/1ps
`include "mac_rx_classify_regs.svh"
module mac_rx_classify_mdio_phy_if_bench;
   logic        clk, rst, wr, rd, mdc, mline, mdrv, oe_n, done, lclk;
   logic        dv, rxer, colp, txen, txer, crs, col, rdone, racc, amatch, rmii;
   logic [7:0]  addr;
   logic [3:0]  rxd, txd;
   logic [31:0] wdata, rdata, st, got;
   int          miscompares = 0;
   int          n_checks = 0;
   mac_rx_classify_mdio_phy_if i_dut (.clk_sys_i(clk), .sys_rst_i(rst),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .mdc_o(mdc), .mdio_i(mline), .mdio_o(mdrv),
      .mdio_oe_n_o(oe_n), .mgmt_done_o(done), .rx_clock_pin_i(lclk),
      .tx_clock_or_ref_clock_pin_i(lclk), .rx_data_pins_i(rxd),
      .rx_data_valid_pin_i(dv), .rx_error_pin_i(rxer), .carrier_sense_pin_i(dv),
      .collision_detect_pin_i(colp), .tx_enable_pin_o(txen), .tx_data_pins_o(txd),
      .tx_error_pin_o(txer), .tx_nibble_i(4'h5), .tx_en_i(1'b1), .tx_err_i(1'b1),
      .tx_nibble_take_o(), .addr_match_i(amatch), .crs_o(crs), .col_o(col),
      .rx_done_o(rdone), .rx_accept_o(racc), .rx_status_o(st));
   phy_link_model i_phy (.mdc_i(mdc), .mdio_drv_i(mdrv), .mdio_oe_n_i(oe_n),
      .mdio_line_o(mline), .lclk_o(lclk), .rxd_o(rxd), .dv_o(dv),
      .rxer_o(rxer), .col_o(colp));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task close_out;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr_r(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task rd_r(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 got = rdata;
   endtask
   function bit rot_ok(input logic [31:0] g, input logic [31:0] w);
      for (int r = 14; r <= 18; r++) if (g === ((w << r) | (w >> (32 - r)))) return 1;
      return 0;
   endfunction
   // Shift timing scales with the divider; reads land mid-shift if asked
   task mg(input logic [1:0] d, input logic [31:0] w, input logic [31:0] e, input bit mid);
      int k;
      wr_r(`OFF_NCFGR, {20'h0, d, 10'h0});
      wr_r(`OFF_MAN, w);
      rd_r(`OFF_NSR);
      chk(got[`NSR_IDLE], 0);
      k = 2;
      if (mid) begin
         repeat (380) @(posedge clk);
         rd_r(`OFF_MAN);
         chk(rot_ok(got, w), 1);
         k = 382;
      end
      for (; k < 9000 && done !== 1; k++) begin
         @(posedge clk);
         #1;
      end
      chk(k >= (512 << d) - 8 && k <= (512 << d) + 8, 1);
      rd_r(`OFF_NSR);
      chk(got[`NSR_IDLE], 1);
      rd_r(`OFF_MAN);
      chk(got, e);
      chk(i_phy.seen, e);
   endtask
   task rx(input int n, input logic [15:0] ty, input logic [15:0] tci, input bit bad,
           input bit err, input bit ea, input logic [31:0] es);
      int k;
      fork
         i_phy.send(n, ty, tci, bad, err, rmii);
         begin
            for (k = 0; k < 30000 && rdone !== 1; k++) begin
               @(posedge clk);
               #1;
            end
            chk(rdone, 1);
            chk(racc, ea);
            if (ea) chk(st, es);
            chk({txen, txer, txd}, rmii ? 6'h21 : 6'h35);
            if (rmii) chk(col, 0);
         end
      join
   endtask
   initial begin
      {wr, rd, amatch, rmii, addr, wdata} = '0;
      rst = 1;
      repeat (16) @(posedge clk);
      rst <= 0;
      rd_r(`OFF_NCFGR);
      chk(got, 32'h0000_0800);
      rd_r(`OFF_TYPE);
      chk(got, 0);
      rd_r(`OFF_USRIO);
      chk(got, 0);
      wr_r(8'h7c, 32'hffff_ffff);
      rd_r(8'h7c);
      chk(got, 0);
      @(posedge clk);
      #1 chk(rdata, 0);
      $display("test regs done");
      mg(2'b00, 32'h5182_abcd, 32'h5182_abcd, 1);
      for (int d = 1; d < 4; d++) mg(d[1:0], 32'h5182_abcd, 32'h5182_abcd, 0);
      mg(2'b10, 32'h6182_0000, 32'h6182_c3a5, 0);
      $display("test management done");
      rx(64, 16'h0800, 0, 0, 0, 0, 0);
      wr_r(`OFF_NCFGR, 32'h0000_0010);
      rx(64, 16'h0800, 0, 0, 0, 1, 0);
      rx(63, 16'h0800, 0, 0, 0, 0, 0);
      rx(64, 16'h0800, 0, 1, 0, 0, 0);
      rx(64, 16'h0800, 0, 0, 1, 0, 0);
      wr_r(`OFF_NCFGR, 32'h0008_0010);
      rx(64, 16'h0800, 0, 1, 0, 1, 0);
      rx(64, 16'h0800, 0, 0, 1, 0, 0);
      wr_r(`OFF_NCFGR, 0);
      wr_r(`OFF_TYPE, 32'h0000_0800);
      rx(64, 16'h0800, 0, 0, 0, 0, 0);
      amatch <= 1;
      rx(64, 16'h0800, 0, 0, 0, 1, 32'h0040_0000);
      rd_r(`OFF_RXSTAT);
      chk(got, 32'h0040_0000);
      rx(64, 16'h0806, 0, 0, 0, 1, 0);
      rx(68, 16'h8100, 16'ha123, 0, 0, 1, 32'h002a_0000);
      rx(68, 16'h8100, 16'h3000, 0, 0, 1, 32'h0033_0000);
      wr_r(`OFF_NCFGR, 32'h0000_0100);
      rx(1536, 16'h0800, 0, 0, 0, 1, 32'h0040_0000);
      rx(1537, 16'h0800, 0, 0, 0, 0, 0);
      $display("test mii receive done");
      wr_r(`OFF_USRIO, 32'h0000_0001);
      rmii = 1;
      rx(68, 16'h8100, 16'he000, 0, 0, 1, 32'h003e_0000);
      $display("test rmii done");
      close_out();
   end
   // Tests need about 80000 cycles
   initial begin
      #1000000;
      miscompares++;
      close_out();
   end
endmodule
